// ---- src/sfx_exec.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Memory bit test low skips next instruction when bit is 0; flags kept.
// - Memory bit test high skips next instruction when bit is 1; flags kept.
// - Accumulator increment sets all four flags, skips when result is zero.
// - Accumulator decrement sets all four flags, skips when result is zero.
// - Memory increment writes back, sets four flags, skips on zero result.
// - Memory decrement writes back, sets four flags, skips on zero result.
// - Stall until low holds the unit until the port bit reads 0.
// - Stall until high holds the unit until the port bit reads 1.
// - Wait and delay instructions do nothing in single-unit mode.
// - Call stores next address at stack pointer, jumps, stack pointer plus 2.
// - Jump loads any target address into the program counter; flags kept.
// - Immediate delay N occupies N+1 cycles.
// - Accumulator delay takes N from accumulator, occupies N+1 cycles.
// - Memory delay takes N from memory byte, occupies N+1 cycles.
// - Delays count in the accumulator, leave it zero, keep flags.
// - Return with value loads accumulator then returns; flags kept.
// - Return lowers stack pointer by 2 and reloads program counter there.
module sfx_exec
  import sfx_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic           mclk,
  input  wire logic           nrst,
  input  wire logic           op_valid,
  input  wire sfx_op_t        op_code,
  input  wire logic [2:0]     op_bit,
  input  wire logic [7:0]     op_imm,
  input  wire logic [AW-1:0]  op_target,
  input  wire logic [7:0]     mem_rdata,
  input  wire logic [7:0]     port_pin,
  input  wire logic           single_unit,
  output logic                op_ready,
  output logic                mem_we,
  output logic [7:0]          mem_wdata,
  output logic                stack_we,
  output logic [7:0]          stack_addr,
  output logic [AW-1:0]       stack_wdata,
  input  wire logic [AW-1:0]  stack_rdata,
  output logic [AW-1:0]       pc,
  output logic [7:0]          stack_pointer,
  output logic [7:0]          accumulator,
  output logic [3:0]          flags,
  output logic                skip_pending
);
  // Return addresses travel on a stack word of at most sixteen bits.
  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("sfx_exec: AW out of range");
  end

  function automatic logic [7:0] step8(
    input logic [7:0] a,
    input logic       inc
  );
    step8 = inc ? a + 8'h01 : a - 8'h01;
  endfunction

  function automatic logic [3:0] step_flags(
    input logic [7:0] a,
    input logic       inc
  );
    logic [8:0] r;
    logic [4:0] h;
    r = inc ? {1'b0, a} + 9'h001 : {1'b0, a} - 9'h001;
    h = inc ? {1'b0, a[3:0]} + 5'h01 : {1'b0, a[3:0]} - 5'h01;
    step_flags = 4'h0;
    step_flags[FLAG_Z] = (r[7:0] == 8'h00);
    step_flags[FLAG_C] = r[8];
    step_flags[FLAG_AC] = h[4];
    step_flags[FLAG_OV] = inc ? (!a[7] && r[7]) : (a[7] && !r[7]);
  endfunction

  function automatic logic is_wait(
    input sfx_op_t op
  );
    is_wait = (op == SFX_WAIT_LOW) || (op == SFX_WAIT_HIGH);
  endfunction

  function automatic logic is_delay(
    input sfx_op_t op
  );
    is_delay = (op == SFX_DELAY_I) || (op == SFX_DELAY_A) || (op == SFX_DELAY_M);
  endfunction

  function automatic logic is_inc(
    input sfx_op_t op
  );
    is_inc = (op == SFX_INC_A) || (op == SFX_INC_M);
  endfunction

  sfx_state_t     state;
  sfx_state_t     next_state;
  logic           wait_level;
  logic           next_wait_level;
  logic [2:0]     wait_bit;
  logic [2:0]     next_wait_bit;
  logic [AW-1:0]  next_pc;
  logic [7:0]     next_sp;
  logic           next_skip;
  logic [7:0]     next_acc;
  logic [3:0]     next_flags;
  logic [7:0]     pin_a;
  logic [7:0]     pin_b;
  logic [AW-1:0]  pc_inc;
  logic           take;
  logic           exec;
  logic           unit_op;
  logic           bit_sel;
  logic [7:0]     mem_step;
  logic           stall_done;
  logic           count_done;

  // Port pins cross in from outside the clock domain.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_a <= 8'h00;
      pin_b <= 8'h00;
    end else begin
      pin_a <= port_pin;
      pin_b <= pin_a;
    end
  end

  assign op_ready = (state == SFX_IDLE);
  assign pc_inc = pc + AW'(PC_STEP);
  assign take = op_valid && op_ready;
  assign exec = take && !skip_pending;
  assign unit_op = !single_unit && (is_wait(op_code) || is_delay(op_code));
  assign bit_sel = mem_rdata[op_bit];
  assign mem_step = step8(mem_rdata, is_inc(op_code));
  assign stall_done = (state == SFX_STALL) && (pin_b[wait_bit] == wait_level);
  assign count_done = (state == SFX_COUNT) && (accumulator == 8'h00);

  // Control group: the sequencer and the pin choice of a running stall.
  always_comb begin
    next_state = state;
    next_wait_level = wait_level;
    next_wait_bit = wait_bit;
    case (state)
      SFX_IDLE: begin
        if (exec && unit_op) begin
          if (is_wait(op_code)) begin
            // The pin choice is latched because op_code and op_bit may change while the stall holds fetch and pc.
            next_wait_level = (op_code == SFX_WAIT_HIGH);
            next_wait_bit = op_bit;
            next_state = SFX_STALL;
          end else begin
            next_state = SFX_COUNT;
          end
        end
      end
      SFX_STALL: begin
        if (stall_done) begin
          next_state = SFX_IDLE;
        end
      end
      SFX_COUNT: begin
        if (count_done) begin
          next_state = SFX_IDLE;
        end
      end
      default: begin
        next_state = SFX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= SFX_IDLE;
      wait_level <= 1'b0;
      wait_bit <= 3'h0;
    end else begin
      state <= next_state;
      wait_level <= next_wait_level;
      wait_bit <= next_wait_bit;
    end
  end

  // Flow group: program counter, stack and the pending skip.
  always_comb begin
    next_pc = pc;
    next_sp = stack_pointer;
    next_skip = skip_pending;
    stack_we = 1'b0;
    stack_addr = stack_pointer;
    stack_wdata = pc_inc;
    case (state)
      SFX_IDLE: begin
        if (take && skip_pending) begin
          next_skip = 1'b0;
          next_pc = pc_inc;
        end else if (take) begin
          next_pc = pc_inc;
          case (op_code)
            SFX_TLOW_M: begin
              next_skip = !bit_sel;
            end
            SFX_THIGH_M: begin
              next_skip = bit_sel;
            end
            SFX_INC_A, SFX_DEC_A: begin
              next_skip = (step8(accumulator, is_inc(op_code)) == 8'h00);
            end
            SFX_INC_M, SFX_DEC_M: begin
              next_skip = (mem_step == 8'h00);
            end
            SFX_WAIT_LOW, SFX_WAIT_HIGH, SFX_DELAY_I, SFX_DELAY_A, SFX_DELAY_M: begin
              if (unit_op) begin
                next_pc = pc;
              end
            end
            SFX_CALL: begin
              stack_we = 1'b1;
              next_sp = stack_pointer + 8'(SP_STEP);
              next_pc = op_target;
            end
            SFX_JUMP: begin
              next_pc = op_target;
            end
            SFX_RET_VAL, SFX_RET: begin
              next_sp = stack_pointer - 8'(SP_STEP);
              stack_addr = next_sp;
              next_pc = stack_rdata;
            end
            default: begin
              next_pc = pc_inc;
            end
          endcase
        end
      end
      SFX_STALL: begin
        if (stall_done) begin
          next_pc = pc_inc;
        end
      end
      SFX_COUNT: begin
        if (count_done) begin
          next_pc = pc_inc;
        end
      end
      default: begin
        next_pc = pc;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pc <= AW'(PC_RST);
      stack_pointer <= SP_RST;
      skip_pending <= 1'b0;
    end else begin
      pc <= next_pc;
      stack_pointer <= next_sp;
      skip_pending <= next_skip;
    end
  end

  // Data group: accumulator, flags and the memory write strobe.
  always_comb begin
    next_acc = accumulator;
    next_flags = flags;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    case (state)
      SFX_IDLE: begin
        if (exec) begin
          case (op_code)
            SFX_INC_A, SFX_DEC_A: begin
              next_acc = step8(accumulator, is_inc(op_code));
              next_flags = step_flags(accumulator, is_inc(op_code));
            end
            SFX_INC_M, SFX_DEC_M: begin
              mem_we = 1'b1;
              mem_wdata = mem_step;
              next_flags = step_flags(mem_rdata, is_inc(op_code));
            end
            SFX_DELAY_I: begin
              if (unit_op) begin
                next_acc = op_imm;
              end
            end
            SFX_DELAY_A: begin
              next_acc = accumulator;
            end
            SFX_DELAY_M: begin
              if (unit_op) begin
                next_acc = mem_rdata;
              end
            end
            SFX_RET_VAL: begin
              next_acc = op_imm;
            end
            default: begin
              next_acc = accumulator;
            end
          endcase
        end
      end
      SFX_COUNT: begin
        // An interrupt touching the accumulator here would change the length.
        if (!count_done) begin
          next_acc = accumulator - 8'h01;
        end
      end
      default: begin
        next_acc = accumulator;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      accumulator <= ACCUM_RST;
      flags <= FLAGS_RST;
    end else begin
      accumulator <= next_acc;
      flags <= next_flags;
    end
  end
endmodule // sfx_exec

// ---- src/sfx_pkg.sv ----
package sfx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int PC_STEP = 1;
  localparam int SP_STEP = 2;
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [ADDR_W-1:0] PC_RST = 12'h000;
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_AC = 2;
  localparam int FLAG_OV = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  typedef enum logic [4:0] {
    SFX_NOP       = 5'h00,
    SFX_TLOW_M    = 5'h01,
    SFX_THIGH_M   = 5'h02,
    SFX_INC_A     = 5'h03,
    SFX_DEC_A     = 5'h04,
    SFX_INC_M     = 5'h05,
    SFX_DEC_M     = 5'h06,
    SFX_WAIT_LOW  = 5'h07,
    SFX_WAIT_HIGH = 5'h08,
    SFX_CALL      = 5'h09,
    SFX_JUMP      = 5'h0A,
    SFX_DELAY_I   = 5'h0B,
    SFX_DELAY_A   = 5'h0C,
    SFX_DELAY_M   = 5'h0D,
    SFX_RET_VAL   = 5'h0E,
    SFX_RET       = 5'h0F
  } sfx_op_t;
  typedef enum logic [1:0] {
    SFX_IDLE  = 2'b00,
    SFX_STALL = 2'b01,
    SFX_COUNT = 2'b11
  } sfx_state_t;
endpackage

// ---- test/sfx_exec_monitor.sv ----
`timescale 1ns/10ps
module sfx_exec_monitor
  import sfx_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input wire logic          mclk,
  input wire logic          nrst,
  input wire logic          op_valid,
  input wire sfx_op_t       op_code,
  input wire logic [2:0]    op_bit,
  input wire logic [7:0]    op_imm,
  input wire logic [AW-1:0] op_target,
  input wire logic [7:0]    mem_rdata,
  input wire logic          single_unit,
  input wire logic          op_ready,
  input wire logic          mem_we,
  input wire logic [7:0]    mem_wdata,
  input wire logic          stack_we,
  input wire logic [7:0]    stack_addr,
  input wire logic [AW-1:0] stack_rdata,
  input wire logic [AW-1:0] pc,
  input wire logic [7:0]    stack_pointer,
  input wire logic [7:0]    accumulator,
  input wire logic [3:0]    flags,
  input wire logic          skip_pending
);
  logic tk;
  assign tk = op_valid && op_ready && !skip_pending;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_test_low: assert property (tk && op_code == SFX_TLOW_M |=>
    skip_pending == !$past(mem_rdata[op_bit]) && $stable(flags)) else $error("low test wrong");
  a_test_high: assert property (tk && op_code == SFX_THIGH_M |=>
    skip_pending == $past(mem_rdata[op_bit]) && $stable(flags)) else $error("high test wrong");
  a_inc_acc: assert property (tk && op_code == SFX_INC_A |=>
    accumulator == $past(accumulator) + 8'h01 && skip_pending == (accumulator == 8'h00))
    else $error("increment wrong");
  a_mem_inc: assert property (tk && op_code == SFX_INC_M |->
    mem_we && mem_wdata == mem_rdata + 8'h01) else $error("memory increment wrong");
  a_single_unit: assert property (tk && single_unit && op_code inside {SFX_WAIT_LOW,
    SFX_WAIT_HIGH, SFX_DELAY_I, SFX_DELAY_A, SFX_DELAY_M} |=> op_ready && pc == $past(pc) + 1'b1)
    else $error("single unit op not a no-op");
  a_call_push: assert property (tk && op_code == SFX_CALL |->
    stack_we && stack_addr == stack_pointer ##1 stack_pointer == $past(stack_pointer) + 8'h02)
    else $error("call push wrong");
  a_jump_pc: assert property (tk && op_code == SFX_JUMP |=>
    pc == $past(op_target) && $stable(flags)) else $error("jump wrong");
  a_delay_zero: assert property (tk && !single_unit && op_code == SFX_DELAY_I &&
    op_imm == 8'h00 |=> !op_ready ##1 op_ready && accumulator == 8'h00) else $error("delay wrong");
  a_ret_value: assert property (tk && op_code == SFX_RET_VAL |=>
    accumulator == $past(op_imm) && pc == $past(stack_rdata) && stack_pointer ==
    $past(stack_pointer) - 8'h02) else $error("return wrong");
  a_skip_nop: assert property (op_valid && op_ready && skip_pending |->
    !mem_we && !stack_we ##1 !skip_pending && $stable(accumulator)) else $error("skip wrong");
  c_call: cover property (tk && op_code == SFX_CALL);
  c_skip: cover property (op_valid && op_ready && skip_pending);
  c_delay: cover property (tk && !single_unit && op_code == SFX_DELAY_M);
endmodule // sfx_exec_monitor

bind sfx_exec sfx_exec_monitor #(.AW(AW)) u_mon (.*);

// ---- test/skip_and_flow_control_exec_tb_top.sv ----
`timescale 1ns/10ps
module skip_and_flow_control_exec_tb_top;
  import sfx_pkg::*;
  logic        mclk = 1'b0, nrst = 1'b0, op_valid = 1'b0, single_unit = 1'b0;
  logic        op_ready, mem_we, stack_we, skip_pending;
  sfx_op_t     op_code = SFX_NOP;
  logic [2:0]  op_bit = 3'h0;
  logic [7:0]  op_imm = 8'h00, mem_rdata = 8'h00, port_pin = 8'h00;
  logic [7:0]  mem_wdata, stack_addr, stack_pointer, accumulator;
  logic [11:0] op_target = 12'h000, stack_rdata = 12'h000, stack_wdata, pc;
  logic [3:0]  flags;
  integer      mismatches = 0, comparisons = 0, cyc = 0, seed = 32'h0a0d4544;
  integer      a = 0, p = 0, s = 0, sk = 0, n, e, i, im, md, bt, tg, rd, su, f = 0, wm;
  sfx_op_t     c;
  always #12.5 mclk = ~mclk;
  sfx_exec uut (.*);
  // Pins change freely so stalls end after a random, bounded time.
  always @(posedge mclk) port_pin <= $random(seed);
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk_reg(input logic [15:0] g, input integer x);
    comparisons++;
    if (g !== x[15:0]) begin
      mismatches++;
      $display("CHECK FAILED %0t register got %h want %h", $time, g, x[15:0]);
    end
  endtask
  task chk_strobe(input logic [15:0] g, input integer x);
    comparisons++;
    if (g !== x[15:0]) begin
      mismatches++;
      $display("CHECK FAILED %0t strobe got %h want %h", $time, g, x[15:0]);
    end
  endtask
  task chk_cycles(input logic [15:0] g, input integer x);
    comparisons++;
    if (g !== x[15:0]) begin
      mismatches++;
      $display("CHECK FAILED %0t cycles got %h want %h", $time, g, x[15:0]);
    end
  endtask
  // Flags after a step of one, from the operand before the step.
  function automatic integer fl(input integer v, input integer inc);
    integer r;
    r = inc ? (v + 1) % 256 : (v + 255) % 256;
    fl = (r == 0) * (1 << FLAG_Z) + (inc ? v == 255 : v == 0) * (1 << FLAG_C)
       + (inc ? v % 16 == 15 : v % 16 == 0) * (1 << FLAG_AC)
       + (inc ? v == 127 : v == 128) * (1 << FLAG_OV);
  endfunction
  always @(posedge mclk) if (++cyc == 40000) begin
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      c = sfx_op_t'(5'({$random(seed)} % 16));
      im = (i % 3) ? {$random(seed)} % 256 : 0;
      md = (i % 4) ? {$random(seed)} % 256 : 255;
      bt = {$random(seed)} % 8;
      tg = {$random(seed)} % 4096;
      rd = {$random(seed)} % 4096;
      su = ({$random(seed)} % 8) == 0;
      op_code <= c; op_valid <= 1'b1; op_imm <= im; mem_rdata <= md;
      op_bit <= bt; op_target <= tg; stack_rdata <= rd; single_unit <= su;
      @(negedge mclk);
      wm = !sk && (c == SFX_INC_M || c == SFX_DEC_M);
      chk_strobe({15'h0, mem_we}, wm);
      if (wm) chk_strobe({8'h00, mem_wdata}, c == SFX_INC_M ? (md + 1) % 256 : (md + 255) % 256);
      chk_strobe({15'h0, stack_we}, !sk && c == SFX_CALL);
      chk_strobe({8'h00, stack_addr}, (!sk && (c == SFX_RET_VAL || c == SFX_RET)) ? (s + 254) % 256 : s);
      if (!sk && c == SFX_CALL) chk_strobe({4'h0, stack_wdata}, (p + 1) % 4096);
      @(posedge mclk);
      // No new instruction is offered while a delay counts down the accumulator.
      op_valid <= 1'b0;
      e = 0;
      p = p + 1;
      if (sk) sk = 0;
      else case (c)
        SFX_TLOW_M:  sk = !md[bt];
        SFX_THIGH_M: sk = md[bt];
        SFX_INC_A:   begin f = fl(a, 1); a = (a + 1) % 256; sk = a == 0; end
        SFX_DEC_A:   begin f = fl(a, 0); a = (a + 255) % 256; sk = a == 0; end
        SFX_INC_M:   begin f = fl(md, 1); sk = md == 255; end
        SFX_DEC_M:   begin f = fl(md, 0); sk = md == 1; end
        SFX_RET:     begin p = rd; s = (s + 254) % 256; end
        SFX_NOP:     e = 0;
        SFX_CALL:    begin p = tg; s = (s + 2) % 256; end
        SFX_JUMP:    p = tg;
        SFX_RET_VAL: begin a = im; p = rd; s = (s + 254) % 256; end
        SFX_WAIT_LOW, SFX_WAIT_HIGH: if (!su) e = -1;
        default: if (!su) begin
          e = (c == SFX_DELAY_I ? im : c == SFX_DELAY_A ? a : md) + 1;
          a = 0;
        end
      endcase
      p = p % 4096;
      n = 0;
      @(negedge mclk);
      while (op_ready !== 1'b1 && n < 600) begin
        n++;
        @(negedge mclk);
      end
      if (e >= 0) chk_cycles(n, e);
      chk_reg({4'h0, pc}, p);
      chk_reg({8'h00, accumulator}, a);
      chk_reg({8'h00, stack_pointer}, s);
      chk_reg({15'h0, skip_pending}, sk);
      chk_reg({12'h000, flags}, f);
    end
    report_and_stop;
  end
endmodule // skip_and_flow_control_exec_tb_top
